// ---- src/fps_pkg.sv ----
// Constants shared by the flyback protection sequencer
package fps_pkg;
  // Clock period in ps (200 MHz)
  localparam int unsigned CLK_PERIOD_PS = 5000;
  // Clock cycles in one millisecond, kept small to avoid 32-bit overflow
  localparam int unsigned CYC_PER_MS = 1_000_000_000 / CLK_PERIOD_PS;
  // Brownout interval in ms and cycles
  localparam int unsigned BROWNOUT_MS = 30;
  localparam int unsigned BROWNOUT_CYC = BROWNOUT_MS * CYC_PER_MS;
  // Undervoltage startup blanking in ms and cycles
  localparam int unsigned UV_BLANK_MS = 45;
  localparam int unsigned UV_BLANK_CYC = UV_BLANK_MS * CYC_PER_MS;
  // Default debounce switching-cycle counts
  localparam int unsigned UV_DEBOUNCE_DEF = 4;
  localparam int unsigned OV_DEBOUNCE_DEF = 4;
  // Width of the long timers
  localparam int unsigned TMR_W = 24;
  // Sequencer states
  typedef enum logic [2:0] {
    FPS_OFF = 3'b000,
    FPS_STARTUP = 3'b001,
    FPS_RUN = 3'b010,
    FPS_AUTO_FAULT = 3'b011,
    FPS_LATCH = 3'b100
  } fps_state_t;
endpackage

// ---- src/fps_debounce.sv ----
// Counts consecutive qualified events of a condition up to one past a limit
`timescale 1ns/10ps
module fps_debounce #(
  parameter int unsigned W = 24
) (
  // Clock and reset
  input wire logic core_clk,
  input wire logic nrst,
  // Count control
  input wire logic step,
  input wire logic cond,
  input wire logic clr,
  input wire logic [W-1:0] limit,
  // Result
  output logic hit
);
  logic [W-1:0] cnt_r;
  logic [W-1:0] cnt_nxt;

  // Next count: advance on step while cond holds, drop when cond falls
  always_comb begin
    cnt_nxt = cnt_r;
    if (clr || !cond) begin
      cnt_nxt = '0;
    end else if (step && cnt_r <= limit) begin
      cnt_nxt = cnt_r + 1'b1;
    end
  end

  // Count register
  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      cnt_r <= '0;
    end else begin
      cnt_r <= cnt_nxt;
    end
  end

  // Fires once the count is beyond the limit
  assign hit = cond && (cnt_r > limit);
endmodule // fps_debounce

// ---- src/fps_sequencer.sv ----
// Protection sequencer of an offline flyback controller
// Behaviour
// - Supply overvoltage and brownout are auto-restart faults.
// - Aux overvoltage, die heat and shutdown pin are latch faults.
// - Auto-restart fault stops gating and holds the switch off.
// - Auto-restart: at turn-off level clear fault, enable startup source.
// - Auto-restart: at turn-on resume switching, repeat while faulted.
// - Latch: at turn-off level enable startup source, keep fault set.
// - Latch: at turn-on level disable startup source, still no switching.
// - Latched fault clears only at the deep-discharge level.
// - Supply above its overvoltage threshold raises a fault.
// - Line current low during conduction over 30 ms raises brownout.
// - Die overtemperature stops gating and latches.
// - Aux winding sampled near end of diode conduction each cycle.
// - Aux undervoltage beyond debounce count raises auto-restart fault.
// - Aux undervoltage ignored for 45 ms blanking after power-on.
// - Aux overvoltage beyond debounce count disables gating and latches.
// - Shutdown pin below threshold enters latch protection.
// - At turn-on during startup disable source and begin switching.
`timescale 1ns/10ps
module fps_sequencer #(
  parameter int unsigned BROWNOUT_CYCLES = fps_pkg::BROWNOUT_CYC,
  parameter int unsigned UV_BLANK_CYCLES = fps_pkg::UV_BLANK_CYC,
  parameter int unsigned UV_DEBOUNCE = fps_pkg::UV_DEBOUNCE_DEF,
  parameter int unsigned OV_DEBOUNCE = fps_pkg::OV_DEBOUNCE_DEF
) (
  // Clock and reset
  input wire logic core_clk,
  input wire logic nrst,
  // Supply level comparators
  input wire logic vdd_on_cmp,
  input wire logic vdd_off_cmp,
  input wire logic vdd_deep_cmp,
  input wire logic vdd_ovp_cmp,
  // Line sense and aux sample comparators
  input wire logic line_low_cmp,
  input wire logic aux_uv_cmp,
  input wire logic aux_ov_cmp,
  // Switching cycle timing
  input wire logic gate_on,
  input wire logic diode_end,
  // Temperature and shutdown pin
  input wire logic otp_cmp,
  input wire logic shutdown_pin_low,
  // Outputs
  output logic gate_enable,
  output logic high_voltage_start_pin,
  output logic auto_fault,
  output logic latch_fault
);
  localparam int unsigned NF = 11;
  localparam int unsigned TW = fps_pkg::TMR_W;

  // Two-stage synchronisers for every comparator flag
  logic [NF-1:0] raw;
  logic [NF-1:0] s1_r;
  logic [NF-1:0] s2_r;
  assign raw = {vdd_on_cmp, vdd_off_cmp, vdd_deep_cmp, vdd_ovp_cmp,
                line_low_cmp, aux_uv_cmp, aux_ov_cmp, gate_on,
                diode_end, otp_cmp, shutdown_pin_low};
  genvar gi;
  generate
    for (gi = 0; gi < NF; gi++) begin : g_sync
      always_ff @(posedge core_clk or negedge nrst) begin
        if (!nrst) begin
          s1_r[gi] <= 1'b0;
          s2_r[gi] <= 1'b0;
        end else begin
          s1_r[gi] <= raw[gi];
          s2_r[gi] <= s1_r[gi];
        end
      end
    end
  endgenerate

  logic von, voff, vdeep, vovp, llow, auv, aov, gon, dend, otp, sdl;
  assign {von, voff, vdeep, vovp, llow, auv, aov, gon, dend, otp, sdl} =
    s2_r;

  // Sequencer state, read by the measurement logic below
  fps_pkg::fps_state_t st_r, st_nxt;

  // Sample aux comparators at the diode-conduction end edge, and
  // hold the line comparator as seen during the last conduction
  logic dend_d_r;
  logic samp;
  logic meas_clr;
  logic auv_s_r, auv_s_nxt, aov_s_r, aov_s_nxt;
  logic line_low_r, line_low_nxt;
  assign samp = dend && !dend_d_r;
  // Stale samples would re-trip a fault at once after a restart
  assign meas_clr = (st_r != fps_pkg::FPS_RUN);
  always_comb begin
    auv_s_nxt = samp ? auv : auv_s_r;
    aov_s_nxt = samp ? aov : aov_s_r;
    line_low_nxt = gon ? llow : line_low_r;
    if (meas_clr) begin
      auv_s_nxt = 1'b0;
      aov_s_nxt = 1'b0;
      line_low_nxt = 1'b0;
    end
  end
  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      dend_d_r <= 1'b0;
      auv_s_r <= 1'b0;
      aov_s_r <= 1'b0;
      line_low_r <= 1'b0;
    end else begin
      dend_d_r <= dend;
      auv_s_r <= auv_s_nxt;
      aov_s_r <= aov_s_nxt;
      line_low_r <= line_low_nxt;
    end
  end

  // Power-on blanking timer for aux undervoltage
  logic [TW-1:0] blank_r, blank_nxt;
  logic blank_done;
  assign blank_done = (blank_r == TW'(UV_BLANK_CYCLES));
  always_comb begin
    blank_nxt = blank_done ? blank_r : blank_r + 1'b1;
  end
  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      blank_r <= '0;
    end else begin
      blank_r <= blank_nxt;
    end
  end

  // Brownout: line current low at every conduction, counted per clock
  logic bo_hit;
  fps_debounce #(.W(TW)) u_bo (
    .core_clk(core_clk),
    .nrst(nrst),
    .step(1'b1),
    .cond(line_low_r),
    .clr(meas_clr),
    .limit(TW'(BROWNOUT_CYCLES)),
    .hit(bo_hit)
  );

  // Aux undervoltage debounce over switching cycles
  logic uv_hit;
  fps_debounce #(.W(TW)) u_uv (
    .core_clk(core_clk),
    .nrst(nrst),
    .step(samp),
    .cond(auv_s_r && blank_done),
    .clr(meas_clr),
    .limit(TW'(UV_DEBOUNCE)),
    .hit(uv_hit)
  );

  // Aux overvoltage debounce over switching cycles
  logic ov_hit;
  fps_debounce #(.W(TW)) u_ov (
    .core_clk(core_clk),
    .nrst(nrst),
    .step(samp),
    .cond(aov_s_r),
    .clr(meas_clr),
    .limit(TW'(OV_DEBOUNCE)),
    .hit(ov_hit)
  );

  // Fault classes
  logic auto_trip, latch_trip;
  assign auto_trip = vovp || bo_hit || uv_hit;
  assign latch_trip = ov_hit || otp || sdl;

  // Sequencer state
  logic hv_r, hv_nxt;
  always_comb begin
    st_nxt = st_r;
    hv_nxt = hv_r;
    case (st_r)
      fps_pkg::FPS_OFF: begin
        hv_nxt = 1'b1;
        st_nxt = fps_pkg::FPS_STARTUP;
      end
      fps_pkg::FPS_STARTUP: begin
        if (latch_trip) begin
          st_nxt = fps_pkg::FPS_LATCH;
        end else if (von) begin
          hv_nxt = 1'b0;
          st_nxt = fps_pkg::FPS_RUN;
        end
      end
      fps_pkg::FPS_RUN: begin
        if (latch_trip) begin
          st_nxt = fps_pkg::FPS_LATCH;
        end else if (auto_trip) begin
          st_nxt = fps_pkg::FPS_AUTO_FAULT;
        end else if (voff) begin
          hv_nxt = 1'b1;
          st_nxt = fps_pkg::FPS_STARTUP;
        end
      end
      fps_pkg::FPS_AUTO_FAULT: begin
        if (latch_trip) begin
          st_nxt = fps_pkg::FPS_LATCH;
        end else if (voff) begin
          hv_nxt = 1'b1;
          st_nxt = fps_pkg::FPS_STARTUP;
        end
      end
      fps_pkg::FPS_LATCH: begin
        if (vdeep) begin
          hv_nxt = 1'b1;
          st_nxt = fps_pkg::FPS_STARTUP;
        end else if (voff) begin
          hv_nxt = 1'b1;
        end else if (von) begin
          hv_nxt = 1'b0;
        end
      end
      default: begin
        st_nxt = fps_pkg::FPS_OFF;
        hv_nxt = 1'b0;
      end
    endcase
  end
  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      st_r <= fps_pkg::FPS_OFF;
      hv_r <= 1'b0;
    end else begin
      st_r <= st_nxt;
      hv_r <= hv_nxt;
    end
  end

  // Outputs from state
  assign gate_enable = (st_r == fps_pkg::FPS_RUN);
  assign high_voltage_start_pin = hv_r;
  assign auto_fault = (st_r == fps_pkg::FPS_AUTO_FAULT);
  assign latch_fault = (st_r == fps_pkg::FPS_LATCH);

  // Sequencing checks
  AST_LATCH_HOLDS: assert property (
    @(posedge core_clk) disable iff (!nrst)
    latch_fault && !vdeep |=> latch_fault)
    else $error("latched fault released without deep discharge");
  AST_LATCH_NO_GATE: assert property (
    @(posedge core_clk) disable iff (!nrst)
    latch_fault |-> !gate_enable)
    else $error("gating while latched");
  AST_LATCH_ENTRY: assert property (
    @(posedge core_clk) disable iff (!nrst)
    gate_enable && latch_trip |=> latch_fault)
    else $error("latch fault not taken");
  AST_AUTO_ENTRY: assert property (
    @(posedge core_clk) disable iff (!nrst)
    gate_enable && vovp && !latch_trip |=> auto_fault && !gate_enable)
    else $error("auto fault not taken");
  AST_AUTO_RESTART: assert property (
    @(posedge core_clk) disable iff (!nrst)
    auto_fault && voff && !latch_trip |=> !auto_fault && hv_r)
    else $error("auto fault not cleared at turn-off");
  AST_LATCH_RECHARGE: assert property (
    @(posedge core_clk) disable iff (!nrst)
    latch_fault && voff && !vdeep |=> hv_r && latch_fault)
    else $error("latched recharge wrong");
  AST_STARTUP_ON: assert property (
    @(posedge core_clk) disable iff (!nrst)
    st_r == fps_pkg::FPS_STARTUP && von && !latch_trip
    |=> gate_enable && !hv_r)
    else $error("startup did not begin switching");
  AST_BLANK: assert property (
    @(posedge core_clk) disable iff (!nrst)
    !blank_done |-> !uv_hit)
    else $error("undervoltage during blanking");
  AST_SYNC: assert property (
    @(posedge core_clk) disable iff (!nrst)
    $rose(otp) |-> $past(otp_cmp, 2))
    else $error("flag not synchronised");
  AST_RUN_HV_OFF: assert property (
    @(posedge core_clk) disable iff (!nrst)
    gate_enable |-> !high_voltage_start_pin)
    else $error("startup source on while switching");
  AST_OTP_LATCH: assert property (
    @(posedge core_clk) disable iff (!nrst)
    gate_enable && otp |=> latch_fault)
    else $error("overtemperature did not latch");
  AST_SD_LATCH: assert property (
    @(posedge core_clk) disable iff (!nrst)
    gate_enable && sdl |=> latch_fault)
    else $error("shutdown pin did not latch");
  AST_OV_LATCH: assert property (
    @(posedge core_clk) disable iff (!nrst)
    gate_enable && ov_hit |=> latch_fault)
    else $error("aux overvoltage did not latch");
  AST_UV_AUTO: assert property (
    @(posedge core_clk) disable iff (!nrst)
    gate_enable && uv_hit && !latch_trip |=> auto_fault)
    else $error("aux undervoltage did not stop switching");
  AST_BO_AUTO: assert property (
    @(posedge core_clk) disable iff (!nrst)
    gate_enable && bo_hit && !latch_trip |=> auto_fault)
    else $error("brownout did not stop switching");
  AST_AUTO_HOLD: assert property (
    @(posedge core_clk) disable iff (!nrst)
    auto_fault && !voff && !latch_trip |=> auto_fault && !hv_r)
    else $error("auto fault left before turn-off level");
  AST_LATCH_HV_OFF: assert property (
    @(posedge core_clk) disable iff (!nrst)
    latch_fault && von && !voff && !vdeep
    |=> !hv_r && latch_fault)
    else $error("startup source left on while latched");
  AST_DEEP_CLEAR: assert property (
    @(posedge core_clk) disable iff (!nrst)
    latch_fault && vdeep |=> !latch_fault && hv_r)
    else $error("latched fault kept at deep discharge");
  AST_AUX_SAMPLE: assert property (
    @(posedge core_clk) disable iff (!nrst)
    samp && !meas_clr
    |=> auv_s_r == $past(auv) && aov_s_r == $past(aov))
    else $error("aux sample not taken");
  AST_MEAS_CLEAR: assert property (
    @(posedge core_clk) disable iff (!nrst)
    meas_clr |=> !uv_hit && !ov_hit && !bo_hit)
    else $error("fault count kept while not switching");
  AST_STARTUP_HOLD: assert property (
    @(posedge core_clk) disable iff (!nrst)
    st_r == fps_pkg::FPS_STARTUP && !von && !latch_trip
    |=> st_r == fps_pkg::FPS_STARTUP && hv_r)
    else $error("startup left before turn-on level");
endmodule // fps_sequencer

// ---- tb/fps_rail_model.sv ----
// Supply rail, power switch and startup source model at the sequencer pins
`timescale 1ns/10ps
module fps_rail_model (
  // Clock and reset
  input wire logic core_clk,
  input wire logic nrst,
  // Mains and sequencer outputs
  input wire logic mains_on,
  input wire logic gate_enable,
  input wire logic high_voltage_start_pin,
  // Supply comparators and switch timing
  output logic vdd_on_cmp,
  output logic vdd_off_cmp,
  output logic vdd_deep_cmp,
  output logic gate_on,
  output logic diode_end
);
  logic [6:0] rail_r;
  logic [6:0] ph_r;
  logic idle;

  // Aux winding holds the rail only while switching
  assign idle = !gate_enable;

  // Rail charges from the startup source, else drains
  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      rail_r <= 7'h00;
      ph_r <= 7'h00;
    end else begin
      if (idle && high_voltage_start_pin && mains_on) begin
        rail_r <= rail_r + 7'h01;
      end else if (idle && rail_r != 7'h00) begin
        rail_r <= rail_r - 7'h01;
      end
      ph_r <= (idle || ph_r == 7'h4f) ? 7'h00 : ph_r + 7'h01;
    end
  end

  // Comparator levels and one 80-cycle switching period
  assign vdd_on_cmp = rail_r >= 7'h46;
  assign vdd_off_cmp = rail_r <= 7'h17;
  assign vdd_deep_cmp = rail_r <= 7'h0a;
  assign gate_on = gate_enable && ph_r < 7'h40;
  assign diode_end = gate_enable && ph_r == 7'h48;
endmodule // fps_rail_model

// ---- tb/flyback_protection_sequencer_tb.sv ----
// Self-checking bench of the flyback protection sequencer
`timescale 1ns/10ps
module flyback_protection_sequencer_tb;
  logic core_clk = 1'b0;
  logic nrst = 1'b0;
  logic mains_on = 1'b1;
  logic [5:0] flt = 6'h04; // ovp, brownout, aux uv, aux ov, otp, shutdown
  logic vdd_on_cmp, vdd_off_cmp, vdd_deep_cmp, gate_on, diode_end;
  logic gate_enable, high_voltage_start_pin, auto_fault, latch_fault;
  logic [31:0] lfsr = 32'he862_4eb3;
  int errors = 0;
  int n_tests = 0;
  int cyc = 0;

  // Clock
  always #2.5 core_clk = ~core_clk;

  // Short timers keep the run brief
  fps_sequencer #(.BROWNOUT_CYCLES(50), .UV_BLANK_CYCLES(1000),
    .UV_DEBOUNCE(4), .OV_DEBOUNCE(4)) dut (
    .core_clk(core_clk), .nrst(nrst), .vdd_on_cmp(vdd_on_cmp),
    .vdd_off_cmp(vdd_off_cmp), .vdd_deep_cmp(vdd_deep_cmp),
    .vdd_ovp_cmp(flt[0]), .line_low_cmp(flt[1]), .aux_uv_cmp(flt[2]),
    .aux_ov_cmp(flt[3]), .gate_on(gate_on), .diode_end(diode_end),
    .otp_cmp(flt[4]), .shutdown_pin_low(flt[5]),
    .gate_enable(gate_enable),
    .high_voltage_start_pin(high_voltage_start_pin),
    .auto_fault(auto_fault), .latch_fault(latch_fault));

  // Far side of the block
  fps_rail_model rail (
    .core_clk(core_clk), .nrst(nrst), .mains_on(mains_on),
    .gate_enable(gate_enable),
    .high_voltage_start_pin(high_voltage_start_pin),
    .vdd_on_cmp(vdd_on_cmp), .vdd_off_cmp(vdd_off_cmp),
    .vdd_deep_cmp(vdd_deep_cmp), .gate_on(gate_on), .diode_end(diode_end));

  // Random source
  function automatic logic [31:0] lfsr_next(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction

  // Expected protection class of each fault input
  function automatic logic latch_class(input int i);
    return i >= 3;
  endfunction

  // Output selected for waiting
  function automatic logic pick(input int w);
    case (w)
      0: return gate_enable;
      1: return high_voltage_start_pin;
      2: return auto_fault;
      default: return latch_fault;
    endcase
  endfunction

  task check(input logic seen, input logic exp);
    n_tests++;
    if (seen !== exp) begin
      errors++;
      $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask

  // Bounded wait for an output level
  task waitv(input int w, input logic v, input int lim);
    int k;
    k = 0;
    while (pick(w) !== v && k < lim) begin
      @(posedge core_clk);
      #1;
      k++;
    end
    if (pick(w) !== v) check(pick(w), v);
  endtask

  task give_verdict();
    if (errors == 0 && n_tests > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask

  // Run limit
  always @(posedge core_clk) begin
    cyc++;
    if (cyc == 20000) begin
      errors++;
      give_verdict();
    end
  end

  // Main sequence
  initial begin
    repeat (6) @(posedge core_clk);
    #1 nrst = 1'b1;
    repeat (2) @(posedge core_clk);
    #1;
    check(high_voltage_start_pin, 1'b1);
    waitv(0, 1'b1, 200);
    check(high_voltage_start_pin, 1'b0);
    repeat (800) @(posedge core_clk);
    #1;
    check(auto_fault, 1'b0);
    waitv(2, 1'b1, 600);
    check(auto_fault, 1'b1);
    flt = 6'h00;
    waitv(0, 1'b1, 400);
    for (int i = 0; i < 6; i++) begin
      lfsr = lfsr_next(lfsr);
      repeat (lfsr[4:0]) @(posedge core_clk);
      #1 flt = 6'h01 << i;
      if (!latch_class(i)) begin
        waitv(2, 1'b1, 600);
        check(auto_fault, 1'b1);
        check(gate_enable, 1'b0);
        waitv(2, 1'b0, 200);
        check(high_voltage_start_pin, 1'b1);
        waitv(0, 1'b1, 200);
        waitv(2, 1'b1, 600);
        check(auto_fault, 1'b1);
        flt = 6'h00;
      end else begin
        waitv(3, 1'b1, 600);
        check(latch_fault, 1'b1);
        check(gate_enable, 1'b0);
        repeat (lfsr[8:5]) @(posedge core_clk);
        #1 flt = 6'h00;
        waitv(1, 1'b1, 200);
        check(latch_fault, 1'b1);
        waitv(1, 1'b0, 200);
        check(latch_fault, 1'b1);
        check(gate_enable, 1'b0);
        mains_on = 1'b0;
        waitv(3, 1'b0, 200);
        check(vdd_deep_cmp, 1'b1);
        mains_on = 1'b1;
      end
      waitv(0, 1'b1, 400);
      check(gate_enable, 1'b1);
    end
    give_verdict();
  end
endmodule // flyback_protection_sequencer_tb
